// ### core/lan_cmd_port.sv
// Behaviour
// - Codes 1, 2, 3 read a word, write a word, move a block.
// - Codes 4, 5, 6 run self-test, jump subroutine, load program from ROM.
// - Station load or chip configure while busy gives 81/83; chip faults 82/84.
// - Header pick: 85 receiver busy, 86 count over twenty, 87 unordered offsets.
// - Multicast load: 88 busy, 89 over twenty addresses, 8A chip fault.
// - Counter read code 0C asking too many counters returns 8B.
// - Transmit start code 0F: 8C already running, 8D null descriptor pointer.
// - Primitive mode faults reported as codes 80 to 85.
// - Crash code 91 without small buffer, 92 without large buffer.
// - Self-test number 00 runs all tests, 01 to 10 run one each.
// - Self-tests run after power-up and after a host reset written while no self-test is running.
// - Four 16-bit shared words at word offsets 0 to 3.
// - Channel A uses word 0, channel B uses word 1.
// - High byte shared by both words, low byte per channel.
// - Words 2 and 3 carry a data structure address.
// - Primitive mode places self-test status or error in words 2 and 3.
// - Handshake bits active at one, inactive at zero.
// - Access permission per bit applies to whoever accesses the word.
// - Channel A carries commands, channel B carries receive traffic.
// - Attention-clear bit write-only, reads zero, writing one clears incoming attention.
// - Attention-request bit write-only, reads zero, writing one sets outgoing attention.
`timescale 1ns/1ps
`default_nettype none
`include "lan_cmd_params.svh"
module lan_cmd_port
  import lan_cmd_pkg::*;
#(
  parameter logic [7:0] STAT_COUNT = `STAT_COUNT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Host slave word port
  input wire logic host_sel_i,
  input wire logic host_we_i,
  input wire logic [1:0] host_addr_i,
  input wire logic [15:0] host_wdata_i,
  output logic [15:0] host_rdata_o,
  output logic host_ack_o,
  output logic irq_o,
  // Command executor
  input wire cond_t cond_i,
  output logic cmd_go_o,
  output logic [7:0] cmd_code_o,
  input wire logic cmd_done_i,
  input wire logic cmd_fault_i,
  // Fault sources
  input wire prim_fault_t prim_fault_i,
  input wire logic no_small_buf_i,
  input wire logic no_large_buf_i,
  // Receive channel
  input wire logic rx_event_i,
  output logic rx_attn_o,
  // Self-test engine and mode output
  output logic test_go_o,
  output logic [7:0] test_num_o,
  input wire logic test_done_i,
  input wire logic test_fail_i,
  output logic link_mode_o
);
  // ==========================================
  // Shared state
  typedef enum logic [1:0] {P_IDLE, P_EXEC, P_TEST} port_st_t;
  port_st_t state_q;
  mode_t mode_q;
  logic ie_q, pa_q, swr_q, mr_q;
  logic [1:0] lg_q, lm_q, lr_q, af_q, am_q, at_q;
  logic [15:0] ptr_hi_q, ptr_lo_q;
  logic [7:0] err_q;
  logic start_q;
  logic [7:0] start_num_q;
  logic irq_pend_a, irq_pend_b, ip, selftest_fail_flag;
  logic st_busy, st_failed, st_finish;
  logic [7:0] chk_err;
  logic [1:0] wr_ch;
  cmd_word_t cmd;
  logic take_cmd, crash, pfault;
  logic [7:0] pf_code;

  assign cmd = cmd_word_t'(ptr_lo_q);
  assign irq_pend_a = af_q[0] & am_q[0];
  assign irq_pend_b = af_q[1] & am_q[1];
  assign ip = irq_pend_a | irq_pend_b;
  assign selftest_fail_flag = st_busy | st_failed;
  assign take_cmd = (state_q == P_IDLE) && at_q[0] && !st_busy;
  assign crash = no_small_buf_i | no_large_buf_i;
  assign pfault = (mode_q == MODE_PRIM) && (|prim_fault_i);

  // Host write strobes per handshake word
  assign wr_ch[0] = host_sel_i && host_we_i && host_addr_i == `W_HS_A;
  assign wr_ch[1] = host_sel_i && host_we_i && host_addr_i == `W_HS_B;

  // Primitive fault priority: lowest code first
  function automatic logic [7:0] prim_code(input prim_fault_t f);
    if (f.bus_timeout) prim_code = `E_P_TIMEOUT;
    else if (f.bus_mem_err) prim_code = `E_P_MEMERR;
    else if (f.parity_err) prim_code = `E_P_PARITY;
    else if (f.bad_addr) prim_code = `E_P_BADADDR;
    else if (f.addr_err) prim_code = `E_P_ADDRERR;
    else prim_code = `E_P_VECTOR;
  endfunction
  assign pf_code = prim_code(prim_fault_i);

  // Chip faults map by command
  function automatic logic [7:0] chip_code(input logic [7:0] code);
    case (code)
      `C_STA_LOAD: chip_code = `E_82;
      `C_CFG_CHIP: chip_code = `E_84;
      `C_MCAST: chip_code = `E_8A;
      default: chip_code = `E_UNKNOWN;
    endcase
  endfunction

  cmd_check #(.STAT_COUNT(STAT_COUNT)) u_check (
    .cmd_i(cmd),
    .mode_i(mode_q),
    .cond_i(cond_i),
    .tdb_null_i(ptr_hi_q == `WORD_RESET),
    .err_o(chk_err)
  );

  selftest_seq u_selftest (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(start_q),
    .num_i(start_num_q),
    .go_o(test_go_o),
    .num_o(test_num_o),
    .done_i(test_done_i),
    .fail_i(test_fail_i),
    .busy_o(st_busy),
    .failed_o(st_failed),
    .finish_o(st_finish)
  );

  // ==========================================
  // Common control bits and self-test launch
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ie_q <= 1'b0;
      swr_q <= 1'b0;
      mr_q <= 1'b0;
      start_q <= 1'b1;
      start_num_q <= `ST_ALL;
    end else begin
      start_q <= 1'b0;
      if (wr_ch[0] | wr_ch[1]) ie_q <= host_wdata_i[`B_IE];
      // Reset bits are set-only by the host and drop when the test run ends
      if ((wr_ch[0] | wr_ch[1]) && (host_wdata_i[`B_SWR] | host_wdata_i[`B_MR])) begin
        swr_q <= swr_q | host_wdata_i[`B_SWR];
        mr_q <= mr_q | host_wdata_i[`B_MR];
        start_q <= 1'b1;
        start_num_q <= `ST_ALL;
      end else if (take_cmd && cmd.code == `C_SELFTEST && chk_err == `E_NONE) begin
        start_q <= 1'b1;
        start_num_q <= cmd.count;
      end else if (st_finish) begin
        swr_q <= 1'b0;
        mr_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Per-channel handshake bits, one layout repeated
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic dev_set_af, dev_clr_at;
    assign dev_set_af = (c == 0) ? (state_q != P_IDLE && (cmd_done_i && state_q == P_EXEC ||
                        st_finish && state_q == P_TEST)) || (take_cmd && chk_err != `E_NONE)
                        : rx_event_i;
    assign dev_clr_at = (c == 0) ? take_cmd : at_q[1];
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        lr_q[c] <= 1'b0;
        lm_q[c] <= 1'b0;
        am_q[c] <= 1'b0;
        lg_q[c] <= 1'b0;
        af_q[c] <= 1'b0;
        at_q[c] <= 1'b0;
      end else begin
        if (wr_ch[c]) begin
          lr_q[c] <= host_wdata_i[`B_LR];
          lm_q[c] <= host_wdata_i[`B_LM];
          am_q[c] <= host_wdata_i[`B_AM];
        end
        lg_q[c] <= lr_q[c] & lm_q[c];
        // Device set wins over a host clear in the same cycle
        if (dev_set_af) af_q[c] <= 1'b1;
        else if (wr_ch[c] && host_wdata_i[`B_AFC]) af_q[c] <= 1'b0;
        if (wr_ch[c] && host_wdata_i[`B_ATR]) at_q[c] <= 1'b1;
        else if (dev_clr_at) at_q[c] <= 1'b0;
      end
    end
  end

  // ==========================================
  // Command sequencer and result words
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= P_IDLE;
      mode_q <= MODE_PRIM;
      cmd_go_o <= 1'b0;
      cmd_code_o <= 8'h00;
      err_q <= `E_NONE;
      pa_q <= 1'b0;
    end else begin
      cmd_go_o <= 1'b0;
      case (state_q)
        P_IDLE: begin
          if (take_cmd) begin
            cmd_code_o <= cmd.code;
            if (chk_err != `E_NONE) begin
              err_q <= chk_err;
            end else if (cmd.code == `C_SELFTEST) begin
              state_q <= P_TEST;
            end else begin
              cmd_go_o <= 1'b1;
              state_q <= P_EXEC;
            end
          end
        end
        P_EXEC: begin
          if (cmd_done_i) begin
            err_q <= cmd_fault_i ? chip_code(cmd_code_o) : `E_NONE;
            if (!cmd_fault_i && cmd_code_o == `C_IPL) mode_q <= MODE_LINK;
            if (!cmd_fault_i && cmd_code_o == `C_TO_PRIM) mode_q <= MODE_PRIM;
            state_q <= P_IDLE;
          end
        end
        P_TEST: begin
          if (st_finish) state_q <= P_IDLE;
        end
        default: state_q <= P_IDLE;
      endcase
      if (crash | pfault) pa_q <= 1'b1;
      else if (wr_ch[0] && host_wdata_i[`B_ATR]) pa_q <= 1'b0;
    end
  end

  // Structure words: host writes, device results take priority
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_hi_q <= `WORD_RESET;
      ptr_lo_q <= `WORD_RESET;
    end else begin
      if (no_small_buf_i) ptr_hi_q <= {8'h00, `E_CRASH_SMALL};
      else if (no_large_buf_i) ptr_hi_q <= {8'h00, `E_CRASH_LARGE};
      else if (pfault) ptr_hi_q <= {8'h00, pf_code};
      else if (st_finish) begin
        ptr_hi_q <= st_failed ? {8'h00, test_num_o} : `SIG_PASS_HI;
        ptr_lo_q <= st_failed ? `WORD_RESET : `SIG_PASS_LO;
      end else if (take_cmd && chk_err != `E_NONE) ptr_hi_q <= {8'h00, chk_err};
      else if (state_q == P_EXEC && cmd_done_i) begin
        ptr_hi_q <= {8'h00, cmd_fault_i ? chip_code(cmd_code_o) : `E_NONE};
      end else if (host_sel_i && host_we_i) begin
        if (host_addr_i == `W_PTR_HI) ptr_hi_q <= host_wdata_i;
        if (host_addr_i == `W_PTR_LO) ptr_lo_q <= host_wdata_i;
      end
    end
  end

  // ==========================================
  // Host read port and registered outputs
  function automatic logic [15:0] hs_word(input logic [1:0] c);
    logic [15:0] w;
    w = 16'h0000;
    w[`B_IP] = ip;
    w[`B_IE] = ie_q;
    w[`B_IPA] = irq_pend_a;
    w[`B_IPB] = irq_pend_b;
    w[`B_PA] = pa_q;
    w[`B_SWR] = swr_q;
    w[`B_MR] = mr_q;
    w[`B_STF] = selftest_fail_flag;
    w[`B_LG] = lg_q[c[0]];
    w[`B_LM] = lm_q[c[0]];
    w[`B_LR] = lr_q[c[0]];
    w[`B_AF] = af_q[c[0]];
    w[`B_AM] = am_q[c[0]];
    w[`B_AT] = at_q[c[0]];
    hs_word = w;
  endfunction

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      host_rdata_o <= 16'h0000;
      host_ack_o <= 1'b0;
      irq_o <= 1'b0;
      rx_attn_o <= 1'b0;
      link_mode_o <= 1'b0;
    end else begin
      host_ack_o <= host_sel_i;
      irq_o <= ip & ie_q;
      rx_attn_o <= at_q[1];
      link_mode_o <= (mode_q == MODE_LINK);
      if (host_sel_i && !host_we_i) begin
        case (host_addr_i)
          `W_HS_A, `W_HS_B: host_rdata_o <= hs_word(host_addr_i);
          `W_PTR_HI: host_rdata_o <= ptr_hi_q;
          default: host_rdata_o <= ptr_lo_q;
        endcase
      end
    end
  end

  // ==========================================
  // Checks
  a_irq_gate: assert property (@(posedge clock_i) disable iff (reset_i)
    irq_o == $past(ip & ie_q)) else $error("interrupt not gated by enable");
  a_read_zero: assert property (@(posedge clock_i) disable iff (reset_i)
    host_sel_i && !host_we_i && host_addr_i[1] == 1'b0 |=>
    host_rdata_o[`B_AFC] == 1'b0 && host_rdata_o[`B_ATR] == 1'b0) else $error("write-only bit read nonzero");
  a_attn_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_ch[1] && host_wdata_i[`B_AFC] && !rx_event_i |=> !af_q[1]) else $error("attention not cleared");
  a_attn_req: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_ch[0] && host_wdata_i[`B_ATR] |=> at_q[0]) else $error("attention request lost");
  a_tx_busy: assert property (@(posedge clock_i) disable iff (reset_i)
    take_cmd && mode_q == MODE_LINK && cmd.code == `C_TX_START && cond_i.tx_active && !crash
    |=> ptr_hi_q[7:0] == `E_8C && af_q[0]) else $error("transmit busy not refused");
  a_hdr_count: assert property (@(posedge clock_i) disable iff (reset_i)
    take_cmd && mode_q == MODE_LINK && cmd.code == `C_HDR_PICK && !cond_i.rx_active &&
    cmd.count > `HDR_MAX && !crash && !pfault |=> ptr_hi_q[7:0] == `E_86) else $error("header count not refused");
  a_unknown_cmd: assert property (@(posedge clock_i) disable iff (reset_i)
    take_cmd && cmd.code > `C_TO_PRIM |=> err_q != `E_NONE && state_q == P_IDLE) else $error("unknown code accepted");
  a_crash_code: assert property (@(posedge clock_i) disable iff (reset_i)
    no_small_buf_i |=> ptr_hi_q[7:0] == `E_CRASH_SMALL && pa_q) else $error("crash code missing");
  a_reset_test: assert property (@(posedge clock_i)
    $fell(reset_i) |-> ##[1:3] test_go_o) else $error("self-test not started after reset");
  a_cmd_issue: assert property (@(posedge clock_i) disable iff (reset_i)
    take_cmd && chk_err == `E_NONE && cmd.code == `C_MOVE |=> cmd_go_o && cmd_code_o == `C_MOVE) else $error("move not issued");
  c_cmd_done: cover property (@(posedge clock_i) disable iff (reset_i) state_q == P_EXEC && cmd_done_i);
  c_test_fail: cover property (@(posedge clock_i) disable iff (reset_i) st_finish && st_failed);
  c_link_mode: cover property (@(posedge clock_i) disable iff (reset_i) $rose(link_mode_o));
endmodule
`default_nettype wire

// ### common/lan_cmd_params.svh
`ifndef LAN_CMD_PARAMS_SVH
`define LAN_CMD_PARAMS_SVH
// ==========================================
// Shared word offsets (word index on the host port)
`define W_HS_A 2'h0
`define W_HS_B 2'h1
`define W_PTR_HI 2'h2
`define W_PTR_LO 2'h3
// ==========================================
// Common bits, bit 15 is the most significant bit of the word
`define B_IP 15
`define B_IE 14
`define B_IPA 13
`define B_IPB 12
`define B_PA 11
`define B_SWR 10
`define B_MR 9
`define B_STF 8
// Per-channel bits
`define B_LG 7
`define B_LM 6
`define B_LR 5
`define B_AF 4
`define B_AM 3
`define B_AFC 2
`define B_AT 1
`define B_ATR 0
// ==========================================
// Command codes
`define C_READ 8'h01
`define C_WRITE 8'h02
`define C_MOVE 8'h03
`define C_SELFTEST 8'h04
`define C_JSR 8'h05
`define C_IPL 8'h06
`define C_READ_ID 8'h07
`define C_STA_LOAD 8'h08
`define C_CFG_CHIP 8'h09
`define C_HDR_PICK 8'h0A
`define C_MCAST 8'h0B
`define C_STAT_RD 8'h0C
`define C_RX_ON 8'h0D
`define C_RX_OFF 8'h0E
`define C_TX_START 8'h0F
`define C_TX_STOP 8'h10
`define C_TIMER_ON 8'h11
`define C_TO_PRIM 8'h12
// ==========================================
// Error codes
`define E_NONE 8'h00
`define E_81 8'h81
`define E_82 8'h82
`define E_83 8'h83
`define E_84 8'h84
`define E_85 8'h85
`define E_86 8'h86
`define E_87 8'h87
`define E_88 8'h88
`define E_89 8'h89
`define E_8A 8'h8A
`define E_8B 8'h8B
`define E_8C 8'h8C
`define E_8D 8'h8D
`define E_P_TIMEOUT 8'h80
`define E_P_MEMERR 8'h81
`define E_P_PARITY 8'h82
`define E_P_BADADDR 8'h83
`define E_P_ADDRERR 8'h84
`define E_P_VECTOR 8'h85
`define E_CRASH_SMALL 8'h91
`define E_CRASH_LARGE 8'h92
`define E_UNKNOWN 8'hFF
// ==========================================
// Limits and reset values
`define HDR_MAX 8'h14
`define MCAST_MAX 8'h14
`define STAT_COUNT 8'h10
`define ST_ALL 8'h00
`define ST_LAST 8'h10
`define SIG_PASS_HI 16'h5A5A
`define SIG_PASS_LO 16'hA5A5
`define WORD_RESET 16'h0000
`endif

// ### common/lan_cmd_pkg.sv
package lan_cmd_pkg;
  typedef enum logic {MODE_PRIM, MODE_LINK} mode_t;
  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic offsets_ascending;
  } cond_t;
  typedef struct packed {
    logic bus_timeout;
    logic bus_mem_err;
    logic parity_err;
    logic bad_addr;
    logic addr_err;
    logic bad_vector;
  } prim_fault_t;
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] code;
  } cmd_word_t;
endpackage

// ### core/cmd_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "lan_cmd_params.svh"
module cmd_check
  import lan_cmd_pkg::*;
#(
  parameter logic [7:0] STAT_COUNT = `STAT_COUNT
) (
  // Command and context
  input wire cmd_word_t cmd_i,
  input wire mode_t mode_i,
  input wire cond_t cond_i,
  input wire logic tdb_null_i,
  // Verdict
  output logic [7:0] err_o
);
  logic busy;
  assign busy = cond_i.tx_active | cond_i.rx_active;

  always_comb begin
    err_o = `E_NONE;
    case (cmd_i.code)
      `C_READ, `C_WRITE, `C_MOVE: err_o = `E_NONE;
      `C_SELFTEST, `C_JSR, `C_IPL: begin
        if (mode_i != MODE_PRIM) err_o = `E_UNKNOWN;
        else if (cmd_i.code == `C_SELFTEST && cmd_i.count > `ST_LAST) err_o = `E_UNKNOWN;
      end
      `C_READ_ID, `C_RX_ON, `C_RX_OFF, `C_TX_STOP, `C_TIMER_ON, `C_TO_PRIM: begin
        if (mode_i != MODE_LINK) err_o = `E_UNKNOWN;
      end
      `C_STA_LOAD: err_o = (mode_i != MODE_LINK) ? `E_UNKNOWN : (busy ? `E_81 : `E_NONE);
      `C_CFG_CHIP: err_o = (mode_i != MODE_LINK) ? `E_UNKNOWN : (busy ? `E_83 : `E_NONE);
      `C_HDR_PICK: begin
        if (mode_i != MODE_LINK) err_o = `E_UNKNOWN;
        else if (cond_i.rx_active) err_o = `E_85;
        else if (cmd_i.count > `HDR_MAX) err_o = `E_86;
        else if (!cond_i.offsets_ascending) err_o = `E_87;
      end
      `C_MCAST: begin
        if (mode_i != MODE_LINK) err_o = `E_UNKNOWN;
        else if (busy) err_o = `E_88;
        else if (cmd_i.count > `MCAST_MAX) err_o = `E_89;
      end
      `C_STAT_RD: begin
        if (mode_i != MODE_LINK) err_o = `E_UNKNOWN;
        else if (cmd_i.count > STAT_COUNT) err_o = `E_8B;
      end
      `C_TX_START: begin
        if (mode_i != MODE_LINK) err_o = `E_UNKNOWN;
        else if (cond_i.tx_active) err_o = `E_8C;
        else if (tdb_null_i) err_o = `E_8D;
      end
      default: err_o = `E_UNKNOWN;
    endcase
  end
endmodule
`default_nettype wire

// ### core/selftest_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "lan_cmd_params.svh"
module selftest_seq (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic [7:0] num_i,
  // Test engine
  output logic go_o,
  output logic [7:0] num_o,
  input wire logic done_i,
  input wire logic fail_i,
  // Result
  output logic busy_o,
  output logic failed_o,
  output logic finish_o
);
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} st_t;
  st_t state_q;
  logic all_q;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
      all_q <= 1'b0;
      num_o <= 8'h00;
      go_o <= 1'b0;
      failed_o <= 1'b0;
      finish_o <= 1'b0;
    end else begin
      go_o <= 1'b0;
      finish_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start_i) begin
            // Number zero walks every test in order
            all_q <= (num_i == `ST_ALL);
            num_o <= (num_i == `ST_ALL) ? 8'h01 : num_i;
            failed_o <= 1'b0;
            state_q <= S_RUN;
          end
        end
        S_RUN: begin
          go_o <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (done_i) begin
            if (fail_i) begin
              failed_o <= 1'b1;
              finish_o <= 1'b1;
              state_q <= S_IDLE;
            end else if (all_q && num_o != `ST_LAST) begin
              num_o <= num_o + 8'h01;
              state_q <= S_RUN;
            end else begin
              finish_o <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign busy_o = (state_q != S_IDLE);
endmodule
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host processor on the shared slave word port
module host_model (
  // Clock
  input wire logic clock_i,
  // Slave word port
  output logic sel_o,
  output logic we_o,
  output logic [1:0] addr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i,
  input wire logic ack_i
);
  logic ack_ok;
  initial begin
    sel_o = 1'b0;
    we_o = 1'b0;
    addr_o = 2'h0;
    wdata_o = 16'h0000;
    ack_ok = 1'b1;
  end
  // One-cycle select per access; answer and data taken a cycle later
  task automatic xfer(input logic we, input logic [1:0] a, input logic [15:0] d, output logic [15:0] q);
    @(negedge clock_i);
    sel_o = 1'b1;
    we_o = we;
    addr_o = a;
    wdata_o = d;
    @(negedge clock_i);
    q = rdata_i;
    ack_ok = ack_i;
    sel_o = 1'b0;
    we_o = 1'b0;
    // Released data lines must not keep the last value
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// ### verif/lan_cmd_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lan_cmd_params.svh"
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin errors++; $display("mismatch %0t %s", $time, m); end end
module lan_cmd_port_tb
  import lan_cmd_pkg::*;
;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] n;
    cond_t k;
    logic f;
    logic z;
    logic [7:0] e;
    logic g;
  } row_t;
  logic clock_i = 1'b0, reset_i = 1'b1, sel, we, ack, irq, go, done, ex_fault = 1'b0, nsb = 1'b0, nlb = 1'b0;
  logic rx_ev = 1'b0, rx_attn, tgo, tdone, tfail, link;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, x;
  logic [7:0] code, tnum, fail_num = 8'hFF, last_num;
  cond_t cond = 3'b001;
  prim_fault_t pf = '0;
  int errors = 0, n_tests = 0, cyc = 0, n_go = 0, n_tgo = 0, n_rx = 0, ex_n = 0, st_n = 0, t0, i;
  row_t rows [0:25] = '{
    '{8'h01, 8'h00, 3'b001, 0, 0, 8'h00, 1}, '{8'h02, 8'h00, 3'b001, 0, 0, 8'h00, 1},
    '{8'h03, 8'h00, 3'b001, 0, 0, 8'h00, 1}, '{8'h05, 8'h00, 3'b001, 0, 0, 8'h00, 1},
    '{8'h07, 8'h00, 3'b001, 0, 0, 8'hFF, 0}, '{8'h20, 8'h00, 3'b001, 0, 0, 8'hFF, 0},
    '{8'h04, 8'h11, 3'b001, 0, 0, 8'hFF, 0}, '{8'h06, 8'h00, 3'b001, 0, 0, 8'h00, 1},
    '{8'h0D, 8'h00, 3'b001, 0, 0, 8'h00, 1}, '{8'h11, 8'h00, 3'b001, 0, 0, 8'h00, 1},
    '{8'h08, 8'h00, 3'b101, 0, 0, 8'h81, 0}, '{8'h08, 8'h00, 3'b001, 1, 0, 8'h82, 1},
    '{8'h09, 8'h00, 3'b011, 0, 0, 8'h83, 0}, '{8'h09, 8'h00, 3'b001, 1, 0, 8'h84, 1},
    '{8'h0A, 8'h00, 3'b011, 0, 0, 8'h85, 0}, '{8'h0A, 8'h15, 3'b001, 0, 0, 8'h86, 0},
    '{8'h0A, 8'h14, 3'b000, 0, 0, 8'h87, 0}, '{8'h0A, 8'h14, 3'b001, 0, 0, 8'h00, 1},
    '{8'h0B, 8'h00, 3'b011, 0, 0, 8'h88, 0}, '{8'h0B, 8'h15, 3'b001, 0, 0, 8'h89, 0},
    '{8'h0B, 8'h14, 3'b001, 1, 0, 8'h8A, 1}, '{8'h0C, 8'h11, 3'b001, 0, 0, 8'h8B, 0},
    '{8'h0F, 8'h00, 3'b101, 0, 0, 8'h8C, 0}, '{8'h0F, 8'h00, 3'b001, 0, 1, 8'h8D, 0},
    '{8'h05, 8'h00, 3'b001, 0, 0, 8'hFF, 0}, '{8'h12, 8'h00, 3'b001, 0, 0, 8'h00, 1}};
  assign tfail = (tnum == fail_num);
  host_model u_host (.clock_i(clock_i), .sel_o(sel), .we_o(we), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .ack_i(ack));
  lan_cmd_port u_dut (.clock_i(clock_i), .reset_i(reset_i), .host_sel_i(sel), .host_we_i(we),
    .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata), .host_ack_o(ack), .irq_o(irq),
    .cond_i(cond), .cmd_go_o(go), .cmd_code_o(code), .cmd_done_i(done), .cmd_fault_i(ex_fault),
    .prim_fault_i(pf), .no_small_buf_i(nsb), .no_large_buf_i(nlb), .rx_event_i(rx_ev),
    .rx_attn_o(rx_attn), .test_go_o(tgo), .test_num_o(tnum), .test_done_i(tdone),
    .test_fail_i(tfail), .link_mode_o(link));
  always #20 clock_i = ~clock_i;
  // ==========================================
  // Executor and self-test engine, three cycles each
  always @(negedge clock_i) begin
    done = 1'b0;
    tdone = 1'b0;
    if (go === 1'b1) ex_n = 3;
    else if (ex_n > 0) begin ex_n--; done = (ex_n == 0); end
    if (tgo === 1'b1) st_n = 3;
    else if (st_n > 0) begin st_n--; tdone = (st_n == 0); end
  end
  always @(posedge clock_i) begin
    n_go += go;
    n_tgo += tgo;
    n_rx += rx_attn;
    if (tgo === 1'b1) last_num = tnum;
    cyc++;
    if (cyc == 20000) begin errors++; results(); end
  end
  // ==========================================
  task automatic results();
    $display("checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    logic [15:0] q;
    u_host.xfer(1'b1, a, d, q);
    `CHK(u_host.ack_ok, 1'b1, "no answer on write")
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] q);
    u_host.xfer(1'b0, a, 16'h0000, q);
  endtask
  task automatic wait_val(input logic [1:0] a, input logic [15:0] m, input logic [15:0] v);
    logic [15:0] q;
    int k;
    rd(a, q);
    for (k = 0; k < 300 && (q & m) !== v; k++) rd(a, q);
    `CHK(q & m, v, "word did not reach value")
  endtask
  task automatic wait_tests(input int n);
    for (int k = 0; k < 3000 && n_tgo - t0 < n; k++) @(posedge clock_i);
    wait_val(`W_HS_A, 16'h0100, 16'h0000);
  endtask
  task automatic cmd(input row_t r);
    int g0;
    cond = r.k;
    ex_fault = r.f;
    g0 = n_go;
    wr(`W_PTR_HI, r.z ? 16'h0000 : 16'h1000);
    wr(`W_PTR_LO, {r.n, r.c});
    wr(`W_HS_A, 16'h0001);
    wait_val(`W_HS_A, 16'h0010, 16'h0010);
    rd(`W_PTR_HI, x);
    `CHK(x[7:0], r.e, "error code")
    `CHK(n_go - g0, int'(r.g), "executor start count")
    `CHK(code, r.c, "executor code")
    wr(`W_HS_A, 16'h0004);
    rd(`W_HS_A, x);
    `CHK({x[`B_AF], x[`B_AFC], x[`B_ATR]}, 3'b000, "attention clear")
  endtask
  // ==========================================
  initial begin
    repeat (10) @(posedge clock_i);
    `CHK({tgo, ack, link}, 3'b000, "outputs during reset")
    @(negedge clock_i);
    reset_i = 1'b0;
    t0 = 0;
    wait_tests(16);
    `CHK(n_tgo, 16, "power-up test count")
    for (i = 0; i < 26; i++) begin
      cmd(rows[i]);
      $display("test row %0d done", i);
    end
    `CHK(link, 1'b0, "mode after return")
    fail_num = 8'h03;
    t0 = n_tgo;
    wr(`W_PTR_LO, 16'h0304);
    wr(`W_HS_A, 16'h0001);
    wait_val(`W_HS_A, 16'h0010, 16'h0010);
    rd(`W_PTR_HI, x);
    `CHK({x, last_num, 8'(n_tgo - t0)}, {16'h0003, 8'h03, 8'h01}, "single test result")
    rd(`W_PTR_LO, x);
    `CHK(x, 16'h0000, "single test low word")
    wait_val(`W_HS_A, 16'h0100, 16'h0100);
    wr(`W_HS_A, 16'h0004);
    $display("test single self-test done");
    fail_num = 8'hFF;
    t0 = n_tgo;
    wr(`W_HS_A, 16'h0400);
    wait_tests(16);
    rd(`W_PTR_HI, x);
    `CHK({x, 8'(n_tgo - t0)}, {16'h5A5A, 8'h10}, "host reset run")
    rd(`W_PTR_LO, x);
    `CHK(x, 16'hA5A5, "host reset low word")
    $display("test host reset done");
    @(negedge clock_i) rx_ev = 1'b1;
    @(negedge clock_i) rx_ev = 1'b0;
    wait_val(`W_HS_B, 16'h0010, 16'h0010);
    t0 = n_rx;
    wr(`W_HS_B, 16'h4009);
    repeat (3) @(negedge clock_i);
    rd(`W_HS_B, x);
    `CHK({8'(n_rx - t0), x[`B_ATR], x[`B_AT]}, 10'h004, "receive attention request")
    `CHK(x[`B_IP], x[`B_IPA] | x[`B_IPB], "any pending")
    `CHK(irq, x[`B_IP] & x[`B_IE], "interrupt gate")
    rd(`W_HS_A, x);
    `CHK(x[`B_IE], 1'b1, "shared enable bit")
    wr(`W_HS_B, 16'h0008);
    rd(`W_HS_B, x);
    `CHK({irq, x[`B_IP], x[`B_IE]}, 3'b010, "interrupt masked")
    wr(`W_HS_B, 16'h000C);
    rd(`W_HS_B, x);
    `CHK({x[`B_AF], x[`B_IP]}, 2'b00, "receive attention clear")
    $display("test receive channel done");
    pf = 6'b001100;
    wait_val(`W_HS_A, 16'h0800, 16'h0800);
    wait_val(`W_PTR_HI, 16'hFFFF, 16'h0082);
    pf = '0;
    nsb = 1'b1;
    nlb = 1'b1;
    wait_val(`W_PTR_HI, 16'h00FF, 16'h0091);
    nsb = 1'b0;
    wait_val(`W_PTR_HI, 16'h00FF, 16'h0092);
    $display("test faults done");
    results();
  end
endmodule
`default_nettype wire
